/* reset_source_ctrl.sv */
// Reset source and sequencing controller for a small microcontroller core.
// Assumes synchronous inputs on clk, a register port with read data one
// cycle after the read strobe, and a core that obeys the defaults outputs.
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`include "reset_ctrl_params.svh"
module reset_source_ctrl
	import reset_ctrl_pkg::*;
#(
	parameter int EXT_DELAY_CYC = `RST_EXT_DELAY_CYC,
	parameter int BOR_DELAY_CYC = `RST_BOR_DELAY_CYC,
	parameter int BOR_QUAL_CYC  = `RST_BOR_QUAL_CYC
)
(
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       ext_reset_pin,
	input  wire logic       supply_low,
	input  wire logic       wdt_timeout,
	input  wire logic       wdt_key_bad,
	input  wire logic       sleep_entry,
	input  wire logic       wakeup,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic [7:0]      reg_rdata,
	output logic            core_reset_n,
	output logic            warm_reset,
	output logic            pin_is_reset,
	output core_defaults_t  core_defaults,
	output logic            timeout_flag,
	output logic            powerdown_flag,
	output logic            sleeping
);

	localparam int DW = $clog2(BOR_DELAY_CYC + 1);

	typedef enum logic [1:0] {
		ST_RUN,
		ST_PEND,
		ST_HOLD,
		ST_RELEASE
	} seq_state_t;

	seq_state_t     state_reg;
	reset_src_t     src_reg;
	reg_req_t       req;
	logic [DW-1:0]  delay_reg;
	logic [1:0]     lat_reg;
	logic [7:0]     pin_sel_reg;
	logic           idle_sysclk_keep;
	logic           reserved_bit_three;
	logic           brownout_flag;
	logic           wdt_ctrl_reset_flag;
	logic           por_seen_reg;
	logic           ext_meta_reg;
	logic           ext_sync_reg;
	logic           bor_qual;
	logic           ext_active;
	logic           hold_req;
	logic           wr_mode;

	assign req        = '{addr: reg_addr, wdata: reg_wdata,
		wr: reg_wr, rd: reg_rd};
	assign wr_mode    = req.wr && req.addr == `RST_ADDR_MODE_CTRL;
	assign ext_active = pin_is_reset && !ext_sync_reg;
	assign hold_req   = ext_active || bor_qual || wdt_key_bad
		|| (wdt_timeout && !sleeping);

	////////////////////////////////////////////////////////////////////////
	// External pin synchroniser

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ext_meta_reg <= 1'b1;
			ext_sync_reg <= 1'b1;
		end
		else
		begin
			ext_meta_reg <= ext_reset_pin;
			ext_sync_reg <= ext_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Brown-out qualification, gated off while asleep

	persist_filter #(
		.QUAL      (BOR_QUAL_CYC)
	) u_bor_filter (
		.clk       (clk),
		.resetn    (resetn),
		.enable    (!sleeping),
		.level_in  (supply_low),
		.qualified (bor_qual)
	);

	////////////////////////////////////////////////////////////////////////
	// Reset sequencer

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_reg <= ST_HOLD;
			src_reg   <= SRC_EXTERNAL;
			delay_reg <= '0;
			lat_reg   <= '0;
		end
		else
		begin
			case (state_reg)
			ST_RUN:
				if (ext_active)
				begin
					state_reg <= ST_HOLD;
					src_reg   <= SRC_EXTERNAL;
				end
				else if (bor_qual || wdt_key_bad
					|| (wdt_timeout && !sleeping))
				begin
					// Internal sources assert 2~3 clocks late
					state_reg <= ST_PEND;
					lat_reg   <= 2'(`RST_ASSERT_LAT);
					src_reg   <= (bor_qual || wdt_key_bad)
						? SRC_BROWNOUT : SRC_WATCHDOG;
				end
			ST_PEND:
				if (ext_active)
				begin
					state_reg <= ST_HOLD;
					src_reg   <= SRC_EXTERNAL;
				end
				else if (lat_reg == 2'h1)
				begin
					state_reg <= ST_HOLD;
					delay_reg <= '0;
				end
				else
					lat_reg <= lat_reg - 2'h1;
			ST_HOLD:
			begin
				delay_reg <= '0;
				if (!ext_active && !bor_qual)
					state_reg <= ST_RELEASE;
			end
			ST_RELEASE:
				if (hold_req && (ext_active || bor_qual))
					state_reg <= ST_HOLD;
				else if ((src_reg == SRC_BROWNOUT
					&& delay_reg == DW'(BOR_DELAY_CYC - 1))
					|| (src_reg != SRC_BROWNOUT
					&& delay_reg == DW'(EXT_DELAY_CYC - 1)))
				begin
					state_reg <= ST_RUN;
					src_reg   <= SRC_NONE;
				end
				else
					delay_reg <= delay_reg + DW'(1);
			default:
				state_reg <= ST_HOLD;
			endcase
		end
	end

	// Asserts at once with resetn, lets go only on a clock edge
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			core_reset_n <= 1'b0;
		else
			core_reset_n <= (state_reg == ST_RUN
				|| state_reg == ST_PEND);
	end

	// Sleep-mode watchdog: PC and SP only, nothing else
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			warm_reset <= 1'b0;
		else
			warm_reset <= wdt_timeout && sleeping
				&& state_reg == ST_RUN;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			core_defaults <= '1;
		else if (wdt_timeout && sleeping && state_reg == ST_RUN)
			core_defaults <= '{pc_clear: 1'b1, sp_clear: 1'b1,
				default: 1'b0};
		else if (state_reg != ST_RUN)
			core_defaults <= '{pc_clear: 1'b1, sp_clear: 1'b0,
				default: 1'b1};
		else
			core_defaults <= '0;
	end

	////////////////////////////////////////////////////////////////////////
	// Power mode

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			sleeping <= 1'b0;
		else if (wakeup || state_reg != ST_RUN)
			sleeping <= 1'b0;
		else if (wdt_timeout && sleeping)
			sleeping <= 1'b0;
		else if (sleep_entry)
			sleeping <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Status flags

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			timeout_flag   <= 1'b0;
			powerdown_flag <= 1'b0;
		end
		else if (wdt_timeout && state_reg == ST_RUN)
		begin
			timeout_flag   <= 1'b1;
			powerdown_flag <= powerdown_flag || sleeping;
		end
		else if (sleep_entry && state_reg == ST_RUN)
			powerdown_flag <= 1'b1;
		// Brown-out leaves both untouched
	end

	////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			pin_sel_reg <= `RST_PIN_SEL_PORT;
		else if (state_reg == ST_HOLD)
			pin_sel_reg <= `RST_PIN_SEL_PORT;
		else if (req.wr && req.addr == `RST_ADDR_PIN_SEL)
			pin_sel_reg <= req.wdata;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			pin_is_reset <= 1'b0;
		else
			pin_is_reset <= pin_sel_reg == `RST_PIN_SEL_RESET;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			idle_sysclk_keep   <= 1'b0;
			reserved_bit_three <= 1'b0;
		end
		else if (wr_mode)
		begin
			idle_sysclk_keep   <= req.wdata[`RST_MC_IDLE_KEEP_BIT];
			reserved_bit_three <= req.wdata[`RST_MC_RSVD3_BIT];
		end
	end

	// Set wins over a same-cycle software clear
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			brownout_flag <= 1'b0;
		else if (bor_qual)
			brownout_flag <= 1'b1;
		else if (wr_mode && !req.wdata[`RST_MC_BROWNOUT_BIT])
			brownout_flag <= 1'b0;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			wdt_ctrl_reset_flag <= 1'b0;
		else if (wdt_key_bad)
			wdt_ctrl_reset_flag <= 1'b1;
		else if (wr_mode && !req.wdata[`RST_MC_WDT_KEY_BIT])
			wdt_ctrl_reset_flag <= 1'b0;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			por_seen_reg <= 1'b1;
		else if (req.rd && req.addr == `RST_ADDR_STATUS)
			por_seen_reg <= 1'b0;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			reg_rdata <= 8'h00;
		else if (!req.rd)
			reg_rdata <= 8'h00;
		else
			case (req.addr)
			`RST_ADDR_PIN_SEL:
				reg_rdata <= pin_sel_reg;
			`RST_ADDR_MODE_CTRL:
				reg_rdata <= {idle_sysclk_keep, 3'h0, reserved_bit_three,
					brownout_flag, 1'b0, wdt_ctrl_reset_flag};
			`RST_ADDR_STATUS:
				reg_rdata <= {4'h0, por_seen_reg,
					state_reg != ST_RUN, powerdown_flag, timeout_flag};
			`RST_ADDR_CTRL:
				reg_rdata <= {7'h00, sleeping};
			default:
				reg_rdata <= 8'h00;
			endcase
	end

endmodule

/* reset_ctrl_params.svh */
// Constants for the reset source controller: register offsets, field
// positions, reset values and timing counts. Definitions only.
`ifndef RESET_CTRL_PARAMS_SVH
`define RESET_CTRL_PARAMS_SVH

`define RST_ADDR_PIN_SEL      4'h0
`define RST_ADDR_MODE_CTRL    4'h1
`define RST_ADDR_STATUS       4'h2
`define RST_ADDR_CTRL         4'h3

`define RST_PIN_SEL_PORT      8'h55
`define RST_PIN_SEL_RESET     8'haa

`define RST_MC_IDLE_KEEP_BIT  7
`define RST_MC_RSVD3_BIT      3
`define RST_MC_BROWNOUT_BIT   2
`define RST_MC_WDT_KEY_BIT    0

`define RST_ST_TIMEOUT_BIT    0
`define RST_ST_POWERDOWN_BIT  1
`define RST_ST_HOLD_BIT       2
`define RST_ST_POR_BIT        3

`define RST_CTRL_SLEEP_BIT    0

// Clock and delays, times in microseconds
`define RST_CLK_KHZ           50000
`define RST_EXT_DELAY_US      16700
`define RST_BOR_DELAY_US      50000
`define RST_BOR_QUAL_US       1000
`define RST_ASSERT_LAT        2
`define RST_EXT_DELAY_CYC     ((`RST_EXT_DELAY_US * `RST_CLK_KHZ) / 1000)
// Scaled first so the product stays inside a 32-bit int
`define RST_BOR_DELAY_CYC     (`RST_BOR_DELAY_US * (`RST_CLK_KHZ / 1000))
`define RST_BOR_QUAL_CYC      ((`RST_BOR_QUAL_US * `RST_CLK_KHZ + 999) / 1000)

`endif

/* reset_ctrl_pkg.sv */
// Types shared by the reset source controller files.
// Assumes reset_ctrl_params.svh is compiled alongside.
package reset_ctrl_pkg;

	typedef enum logic [1:0] {
		SRC_NONE,
		SRC_EXTERNAL,
		SRC_BROWNOUT,
		SRC_WATCHDOG
	} reset_src_t;

	typedef struct packed {
		logic       pc_clear;
		logic       sp_clear;
		logic       sp_top;
		logic       irq_disable;
		logic       wdt_restart;
		logic       timers_off;
		logic       ports_input;
	} core_defaults_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

endpackage

/* persist_filter.sv */
// Counts how long a level input has stood high and flags it once it has
// stood for QUAL cycles. Assumes a synchronous input and one clock.
`timescale 1ns/1ns
module persist_filter
#(
	parameter int QUAL = 16
)
(
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic enable,
	input  wire logic level_in,
	output logic      qualified
);

	localparam int CW = $clog2(QUAL + 1);

	logic [CW-1:0] count_reg;

	// Short episodes drop the count back to zero, never reaching QUAL
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			count_reg <= '0;
		else if (!enable || !level_in)
			count_reg <= '0;
		else if (count_reg != CW'(QUAL))
			count_reg <= count_reg + CW'(1);
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			qualified <= 1'b0;
		else
			qualified <= enable && level_in && (count_reg >= CW'(QUAL - 1));
	end

endmodule

/* reset_ctrl_properties.sv */
// Timing checks on the reset controller ports.
// Assumes one clock domain and bind to every controller instance.
`timescale 1ns/1ns
module reset_ctrl_properties
	import reset_ctrl_pkg::*;
#(
	parameter int EXT_DELAY_CYC = 20
)
(
	input wire logic           clk,
	input wire logic           resetn,
	input wire logic           wdt_timeout,
	input wire logic [3:0]     reg_addr,
	input wire logic           reg_rd,
	input wire logic [7:0]     reg_rdata,
	input wire logic           core_reset_n,
	input wire logic           warm_reset,
	input wire logic           pin_is_reset,
	input wire core_defaults_t core_defaults,
	input wire logic           timeout_flag,
	input wire logic           powerdown_flag,
	input wire logic           sleeping
);
int low_cnt;
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
////////////////////////////////////////////////////////////////////////////
always_ff @(posedge clk or negedge resetn)
	if (!resetn)
		low_cnt <= 0;
	else if (core_reset_n)
		low_cnt <= 0;
	else
		low_cnt <= low_cnt + 1;
property p_mc_zero;
	$past(reg_rd) && $past(reg_addr) == 4'h1 |-> (reg_rdata & 8'h72) == 8'h00;
endproperty
a_mc_zero: assert property (p_mc_zero) else $error("unused bits set");
property p_wdt_flag;
	wdt_timeout && core_reset_n |=> timeout_flag;
endproperty
a_wdt_flag: assert property (p_wdt_flag) else $error("timeout flag");
property p_wdt_rst;
	wdt_timeout && !sleeping && core_reset_n |-> ##[3:5] !core_reset_n;
endproperty
a_wdt_rst: assert property (p_wdt_rst) else $error("no wdt reset");
property p_warm;
	wdt_timeout && sleeping && core_reset_n |-> ##[1:3] warm_reset;
endproperty
a_warm: assert property (p_warm) else $error("no warm reset");
property p_warm_only;
	warm_reset |-> core_reset_n && core_defaults == 7'h60;
endproperty
a_warm_only: assert property (p_warm_only) else $error("warm scope");
property p_warm_flags;
	warm_reset |-> ##[0:2] (timeout_flag && powerdown_flag);
endproperty
a_warm_flags: assert property (p_warm_flags) else $error("warm flags");
property p_warm_pin;
	warm_reset && pin_is_reset |=> pin_is_reset;
endproperty
a_warm_pin: assert property (p_warm_pin) else $error("pin sel lost");
property p_full;
	!core_reset_n && !$past(core_reset_n)
		|-> (core_defaults & 7'h5f) == 7'h5f;
endproperty
a_full: assert property (p_full) else $error("defaults off");
property p_rel_len;
	$rose(core_reset_n) |-> low_cnt >= EXT_DELAY_CYC - 1;
endproperty
a_rel_len: assert property (p_rel_len) else $error("release early");
property p_rst_pin;
	$fell(core_reset_n) |-> ##[0:3] !pin_is_reset;
endproperty
a_rst_pin: assert property (p_rst_pin) else $error("pin sel kept");
endmodule
bind reset_source_ctrl reset_ctrl_properties
	#(.EXT_DELAY_CYC(EXT_DELAY_CYC)) u_props
	(.clk(clk), .resetn(resetn), .wdt_timeout(wdt_timeout),
	.reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.core_reset_n(core_reset_n), .warm_reset(warm_reset),
	.pin_is_reset(pin_is_reset), .core_defaults(core_defaults),
	.timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
	.sleeping(sleeping));

/* supply_model.sv */
// External reset pin and supply monitor in front of the controller.
// Assumes the bench pulses sag_go for one cycle.
`timescale 1ns/1ns
module supply_model
(
	input wire logic       clk,
	input wire logic       ext_hold,
	input wire logic       sag_go,
	input wire logic [7:0] sag_len,
	output logic           ext_reset_pin,
	output logic           supply_low
);
logic [7:0] left_reg;
initial left_reg = 8'h00;
// Pull-up takes the pin high once released
assign ext_reset_pin = !ext_hold;
assign supply_low = left_reg != 8'h00;
always @(posedge clk)
	if (sag_go)
		left_reg <= sag_len;
	else if (left_reg != 8'h00)
		left_reg <= left_reg - 8'h01;
endmodule

/* tb_top.sv */
// Self-checking bench for the reset source controller.
// Assumes short delay parameters so the run stays brief.
`timescale 1ns/1ns
module tb_top;
import reset_ctrl_pkg::*;
typedef struct packed {logic wr; logic [3:0] a; logic [7:0] v;} row_t;
logic clk = 0, resetn = 0, wdt_timeout = 0, wdt_key_bad = 0, wakeup = 0;
logic sleep_entry = 0, reg_wr = 0, reg_rd = 0, ext_hold = 0, sag_go = 0;
logic [3:0] reg_addr = 4'h0;
logic [7:0] reg_wdata = 8'h00, sag_len = 8'h00, d, reg_rdata;
logic ext_reset_pin, supply_low, core_reset_n, warm_reset, pin_is_reset;
logic timeout_flag, powerdown_flag, sleeping;
core_defaults_t core_defaults;
int num_errors = 0, num_checks = 0;
// Selectors for the pulse task
localparam int K_WDT = 0, K_KEY = 1, K_SLEEP = 2, K_SAG = 3, K_WAKE = 4;
row_t rows[9] = '{'{0,4'h2,8'h08}, '{0,4'h2,8'h00}, '{0,4'h1,8'h00},
	'{1,4'h1,8'hff}, '{0,4'h1,8'h88}, '{0,4'h0,8'h55}, '{1,4'h0,8'haa},
	'{0,4'h0,8'haa}, '{0,4'h9,8'h00}};
reset_source_ctrl #(.EXT_DELAY_CYC(20), .BOR_DELAY_CYC(30), .BOR_QUAL_CYC(4))
	dut (.clk(clk), .resetn(resetn), .ext_reset_pin(ext_reset_pin),
	.supply_low(supply_low), .wdt_timeout(wdt_timeout),
	.wdt_key_bad(wdt_key_bad), .sleep_entry(sleep_entry), .wakeup(wakeup),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_reset_n(core_reset_n),
	.warm_reset(warm_reset), .pin_is_reset(pin_is_reset),
	.core_defaults(core_defaults), .timeout_flag(timeout_flag),
	.powerdown_flag(powerdown_flag), .sleeping(sleeping));
supply_model partner (.clk(clk), .ext_hold(ext_hold), .sag_go(sag_go),
	.sag_len(sag_len), .ext_reset_pin(ext_reset_pin),
	.supply_low(supply_low));
initial
begin
	forever #10 clk = ~clk;
end
////////////////////////////////////////////////////////////////////////////
task automatic wrap_up;
	$display("checks %0d mismatches %0d", num_checks, num_errors);
	if (num_errors == 0 && num_checks > 0)
		$display("Run complete: PASS");
	else
		$display("Run complete: FAIL");
	$finish;
endtask
task automatic chk(input logic [7:0] got, input logic [7:0] exp);
	num_checks++;
	if (got !== exp)
	begin
		num_errors++;
		$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
	end
endtask
task automatic cyc(input int n);
	repeat (n) @(posedge clk);
endtask
task automatic wt(input logic v);
	int k;
	// Look 1 ns after each edge has settled; the first look is taken at once, on entry
	for (k = 0; k < 200 && core_reset_n !== v; k++)
	begin
		@(posedge clk);
		#1;
	end
	if (core_reset_n !== v)
	begin
		num_errors++;
		wrap_up();
	end
endtask
task automatic wr(input logic [3:0] a, input logic [7:0] v);
	@(posedge clk);
	reg_addr <= a;
	reg_wdata <= v;
	reg_wr <= 1'b1;
	@(posedge clk);
	reg_wr <= 1'b0;
endtask
task automatic rd(input logic [3:0] a);
	@(posedge clk);
	reg_addr <= a;
	reg_rd <= 1'b1;
	@(posedge clk);
	reg_rd <= 1'b0;
	#1 d = reg_rdata;
endtask
// Pulses only reach the design off the sampling edge
task automatic kick(input int which);
	@(posedge clk);
	case (which)
	K_WDT:   wdt_timeout <= 1'b1;
	K_KEY:   wdt_key_bad <= 1'b1;
	K_SLEEP: sleep_entry <= 1'b1;
	K_SAG:   sag_go <= 1'b1;
	default: wakeup <= 1'b1;
	endcase
	@(posedge clk);
	wdt_timeout <= 1'b0;
	wdt_key_bad <= 1'b0;
	sleep_entry <= 1'b0;
	sag_go <= 1'b0;
	wakeup <= 1'b0;
endtask
task automatic sag(input logic [7:0] n);
	sag_len <= n;
	kick(K_SAG);
endtask
////////////////////////////////////////////////////////////////////////////
initial
begin
	cyc(3);
	resetn <= 1'b1;
	wt(1);
	foreach (rows[i])
		if (rows[i].wr)
			wr(rows[i].a, rows[i].v);
		else
		begin
			rd(rows[i].a);
			chk(d, rows[i].v);
		end
	$display("register table done");
	kick(K_WDT);
	wt(0);
	cyc(2);
	chk({1'b0, core_defaults}, 8'h5f);
	wt(1);
	rd(4'h0);
	chk(d, 8'h55);
	rd(4'h2);
	chk(d, 8'h01);
	$display("watchdog normal done");
	sag(8'h02);
	cyc(12);
	chk({7'h0, core_reset_n}, 8'h01);
	sag(8'h0a);
	wt(0);
	wt(1);
	kick(K_KEY);
	wt(0);
	wt(1);
	rd(4'h1);
	chk(d & 8'h05, 8'h05);
	rd(4'h2);
	chk(d, 8'h01);
	wr(4'h1, 8'h00);
	rd(4'h1);
	chk(d & 8'h05, 8'h00);
	$display("brownout and key done");
	wr(4'h0, 8'haa);
	kick(K_SLEEP);
	cyc(2);
	chk({7'h0, sleeping}, 8'h01);
	rd(4'h3);
	chk(d, 8'h01);
	sag(8'h0a);
	cyc(15);
	chk({7'h0, core_reset_n}, 8'h01);
	kick(K_WDT);
	#1;
	chk({7'h0, warm_reset}, 8'h01);
	chk({1'b0, core_defaults}, 8'h60);
	cyc(4);
	chk({7'h0, core_reset_n}, 8'h01);
	rd(4'h2);
	chk(d, 8'h03);
	rd(4'h0);
	chk(d, 8'haa);
	kick(K_SLEEP);
	kick(K_WAKE);
	rd(4'h3);
	chk(d, 8'h00);
	$display("watchdog sleep done");
	cyc(1);
	ext_hold <= 1'b1;
	wt(0);
	cyc(5);
	chk({7'h0, core_defaults.pc_clear}, 8'h01);
	rd(4'h2);
	chk(d & 8'h04, 8'h04);
	ext_hold <= 1'b0;
	wt(1);
	rd(4'h0);
	chk(d, 8'h55);
	$display("external reset done");
	cyc(1);
	resetn <= 1'b0;
	cyc(3);
	resetn <= 1'b1;
	wt(1);
	rd(4'h2);
	chk(d, 8'h08);
	$display("power-on again done");
	wrap_up();
end
endmodule
